// ===== hdl/codec_mixer_control_registers.sv
// mixer and output control register bank: aux3 mix, mic mix, mono/misc,
// DAC1 analog gain, plus deferred application of DAC1 and DAC2 gain words
// assumes a one-cycle strobe register port on clk; power enables come from
// other registers on the same clock; pin-sourced inputs are synchronised here
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module codec_mixer_control_registers #(
  parameter int unsigned DEFER_LIMIT = mixer_ctrl_pkg::DEFER_CYCLES
) (
  input  wire logic                               clk,
  input  wire logic                               reset_n,
  input  wire logic [mixer_ctrl_pkg::ADDR_W-1:0]  addr,
  input  wire logic [mixer_ctrl_pkg::DATA_W-1:0]  wrData,
  input  wire logic                               wrStrobe,
  input  wire logic                               rdStrobe,
  output logic      [mixer_ctrl_pkg::DATA_W-1:0]  rdData,
  input  wire logic                               powerDownPin_n,
  input  wire logic                               conversionPowerDown,
  input  wire logic                               analogInputMixEnable,
  input  wire logic                               analogChannelEnable,
  input  wire logic                               dac1Enable,
  input  wire logic                               dac2Enable,
  input  wire logic                               dac1ZeroCross,
  input  wire logic                               dac2ZeroCross,
  input  wire logic [mixer_ctrl_pkg::DATA_W-1:0]  dac2GainWord,
  input  wire logic                               dac2GainLoad,
  output logic                                    leftAux3MixMute,
  output logic      [4:0]                         leftAux3MixGain,
  output logic                                    rightAux3MixMute,
  output logic      [4:0]                         rightAux3MixGain,
  output logic                                    leftMicMixMute,
  output logic      [4:0]                         leftMicMixGain,
  output logic                                    rightMicMixMute,
  output logic      [4:0]                         rightMicMixGain,
  output logic                                    monoInMixMute,
  output logic      [4:0]                         monoInMixGain,
  output logic                                    allMixMute,
  output logic                                    monoOutMute,
  output logic                                    headphoneMute,
  output logic                                    headphoneSwingSel,
  output logic                                    sumInputMute,
  output logic                                    leftDac1AnalogMute,
  output logic      [5:0]                         leftDac1AnalogGain,
  output logic                                    rightDac1AnalogMute,
  output logic      [5:0]                         rightDac1AnalogGain,
  output logic                                    dac1GainPending,
  output logic      [mixer_ctrl_pkg::DATA_W-1:0]  dac2AppliedGain,
  output logic                                    dac2GainPending
);
  import mixer_ctrl_pkg::*;

  // storage
  logic [15:0] aux3_r;
  logic [15:0] mic_r;
  logic [15:0] misc_r;
  logic [15:0] dac1_r;
  logic [15:0] rdData_r;
  logic [15:0] rdSel;
  logic [4:0]  effMute_r;  // aux3 L/R, mic L/R, mono with all-mix override

  // pin synchronisers: first stage is read only by the second
  logic pdnMeta_r;
  logic pdnSync_r;
  logic zc1Meta_r;
  logic zc1Sync_r;
  logic zc2Meta_r;
  logic zc2Sync_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pdnMeta_r <= 1'b0;
      pdnSync_r <= 1'b0;
      zc1Meta_r <= 1'b0;
      zc1Sync_r <= 1'b0;
      zc2Meta_r <= 1'b0;
      zc2Sync_r <= 1'b0;
    end else begin
      pdnMeta_r <= powerDownPin_n;
      pdnSync_r <= pdnMeta_r;
      zc1Meta_r <= dac1ZeroCross;
      zc1Sync_r <= zc1Meta_r;
      zc2Meta_r <= dac2ZeroCross;
      zc2Sync_r <= zc2Meta_r;
    end
  end

  // global gate: power-down pin and conversion power-down
  wire allOk  = pdnSync_r & ~conversionPowerDown;
  // mix gate adds the input-mix and analog-channel enables
  wire mixOk  = allOk & analogInputMixEnable & analogChannelEnable;
  wire dac1Ok = allOk & analogChannelEnable & dac1Enable;
  wire dac2Ok = allOk & analogChannelEnable & dac2Enable;

  // write decode
  wire wrAux3 = wrStrobe && (addr == ADDR_AUX3_MIX);
  wire wrMic  = wrStrobe && (addr == ADDR_MIC_MIX);
  wire wrMisc = wrStrobe && (addr == ADDR_MONO_MISC);
  wire wrDac1 = wrStrobe && (addr == ADDR_DAC1_GAIN);

  // reserved bits never stored, so they read back zero whatever the host sends
  wire [15:0] mixData  = wrData & MIX_MASK;
  wire [15:0] miscData = wrData & MISC_MASK;
  wire [15:0] dac1Data = wrData & DAC_GAIN_MASK;

  // mix registers held at 8888 and locked while mixing is off
  wire [15:0] aux3_nxt = !mixOk ? MIX_RST : (wrAux3 ? mixData : aux3_r);
  wire [15:0] mic_nxt  = !mixOk ? MIX_RST : (wrMic ? mixData : mic_r);

  // misc: upper byte follows the mix gate, lower byte only the global one
  wire [7:0]  miscHi_nxt = !mixOk ? MISC_RST[15:8] : (wrMisc ? miscData[15:8] : misc_r[15:8]);
  wire [7:0]  miscLo_nxt = !allOk ? MISC_RST[7:0] : (wrMisc ? miscData[7:0] : misc_r[7:0]);
  wire [15:0] misc_nxt   = {miscHi_nxt, miscLo_nxt};

  // DAC1 analog gain, cleared with analog channels or DAC1 off
  wire [15:0] dac1_nxt = !dac1Ok ? DAC_GAIN_RST : (wrDac1 ? dac1Data : dac1_r);

  // all-mix mute overrides the individual mute bits of every source
  wire        allMix_nxt  = misc_nxt[ALL_MIX_BIT];
  wire [4:0]  effMute_nxt = {aux3_nxt[LEFT_MUTE_BIT], aux3_nxt[RIGHT_MUTE_BIT],
                             mic_nxt[LEFT_MUTE_BIT], mic_nxt[RIGHT_MUTE_BIT],
                             misc_nxt[LEFT_MUTE_BIT]} | {5{allMix_nxt}};

  // register update; the gates act every cycle, so a lift needs a fresh write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aux3_r    <= MIX_RST;
      mic_r     <= MIX_RST;
      misc_r    <= MISC_RST;
      dac1_r    <= DAC_GAIN_RST;
      effMute_r <= 5'h1F;
    end else begin
      aux3_r    <= aux3_nxt;
      mic_r     <= mic_nxt;
      misc_r    <= misc_nxt;
      dac1_r    <= dac1_nxt;
      effMute_r <= effMute_nxt;
    end
  end

  // read decode; unmapped offsets read zero
  always_comb begin
    if (addr == ADDR_AUX3_MIX) begin
      rdSel = aux3_r;
    end else if (addr == ADDR_MIC_MIX) begin
      rdSel = mic_r;
    end else if (addr == ADDR_MONO_MISC) begin
      rdSel = misc_r;
    end else if (addr == ADDR_DAC1_GAIN) begin
      rdSel = dac1_r;
    end else begin
      rdSel = 16'h0000;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdData_r <= 16'h0000;
    end else begin
      rdData_r <= rdStrobe ? rdSel : 16'h0000;
    end
  end
  assign rdData = rdData_r;

  // deferral units: DAC1 gain from this bank, DAC2 gain from its own register
  gain_defer_if d1 ();
  gain_defer_if d2 ();

  // DAC1 timing bit steers its deferral unit
  assign d1.newWord   = dac1Data;
  assign d1.load      = wrDac1 & dac1Ok;
  assign d1.immediate = misc_r[DAC1_TIME_BIT];
  assign d1.zeroCross = zc1Sync_r;
  assign d1.clear     = ~dac1Ok;

  // DAC2 timing bit steers the other unit
  assign d2.newWord   = dac2GainWord;
  assign d2.load      = dac2GainLoad & dac2Ok;
  assign d2.immediate = misc_r[DAC2_TIME_BIT];
  assign d2.zeroCross = zc2Sync_r;
  assign d2.clear     = ~dac2Ok;

  gain_defer #(
    .RST_WORD    (DAC_GAIN_RST),
    .DEFER_LIMIT (DEFER_LIMIT)
  ) u_dac1_defer (
    .clk     (clk),
    .reset_n (reset_n),
    .dfr     (d1)
  );

  gain_defer #(
    .RST_WORD    (DAC_GAIN_RST),
    .DEFER_LIMIT (DEFER_LIMIT)
  ) u_dac2_defer (
    .clk     (clk),
    .reset_n (reset_n),
    .dfr     (d2)
  );

  // mix fields, mutes carry the all-mix override
  assign leftAux3MixMute  = effMute_r[4];
  assign rightAux3MixMute = effMute_r[3];
  assign leftMicMixMute   = effMute_r[2];
  assign rightMicMixMute  = effMute_r[1];
  assign monoInMixMute    = effMute_r[0];
  assign leftAux3MixGain  = aux3_r[LEFT_MIX_LSB +: MIX_GAIN_W];
  assign rightAux3MixGain = aux3_r[RIGHT_MIX_LSB +: MIX_GAIN_W];
  assign leftMicMixGain   = mic_r[LEFT_MIX_LSB +: MIX_GAIN_W];
  assign rightMicMixGain  = mic_r[RIGHT_MIX_LSB +: MIX_GAIN_W];
  assign monoInMixGain    = misc_r[LEFT_MIX_LSB +: MIX_GAIN_W];

  assign allMixMute        = misc_r[ALL_MIX_BIT];
  assign monoOutMute       = misc_r[MONO_OUT_BIT];
  assign headphoneMute     = misc_r[HP_MUTE_BIT];
  assign headphoneSwingSel = misc_r[HP_SWING_BIT];
  assign sumInputMute      = misc_r[SUM_MUTE_BIT];

  // applied DAC1 gain, not the written word while a change waits
  assign leftDac1AnalogMute  = d1.applied[LEFT_MUTE_BIT];
  assign rightDac1AnalogMute = d1.applied[RIGHT_MUTE_BIT];
  assign leftDac1AnalogGain  = d1.applied[LEFT_MIX_LSB +: DAC_GAIN_W];
  assign rightDac1AnalogGain = d1.applied[RIGHT_MIX_LSB +: DAC_GAIN_W];
  assign dac1GainPending     = d1.pending;
  assign dac2AppliedGain     = d2.applied;
  assign dac2GainPending     = d2.pending;

  // checks
  a_global_clear: assert property (@(posedge clk) disable iff (!reset_n)
    !allOk |=> aux3_r == MIX_RST && mic_r == MIX_RST && misc_r == MISC_RST)
    else $error("registers not at default under power-down");
  a_mix_lock: assert property (@(posedge clk) disable iff (!reset_n)
    !mixOk && wrAux3 |=> aux3_r == MIX_RST)
    else $error("aux3 mix accepted a write while mix disabled");
  a_misc_low: assert property (@(posedge clk) disable iff (!reset_n)
    allOk && !mixOk && wrMisc
      |=> misc_r[7:0] == $past(miscData[7:0]) && misc_r[15:8] == MISC_RST[15:8])
    else $error("misc byte gating wrong");
  a_mic_write: assert property (@(posedge clk) disable iff (!reset_n)
    mixOk && wrMic |=> mic_r == $past(mixData))
    else $error("mic mix write lost");
  a_all_mute: assert property (@(posedge clk) disable iff (!reset_n)
    allMixMute |-> effMute_r == 5'h1F)
    else $error("all-mix mute did not override sources");
  a_mute_pass: assert property (@(posedge clk) disable iff (!reset_n)
    !allMixMute |-> leftAux3MixMute == aux3_r[LEFT_MUTE_BIT]
                 && rightAux3MixMute == aux3_r[RIGHT_MUTE_BIT])
    else $error("aux3 mute does not follow its bit");
  a_dac1_clear: assert property (@(posedge clk) disable iff (!reset_n)
    !dac1Ok |=> dac1_r == DAC_GAIN_RST && leftDac1AnalogMute && rightDac1AnalogMute)
    else $error("DAC1 gain not defaulted when disabled");
  a_read_slot: assert property (@(posedge clk) disable iff (!reset_n)
    rdStrobe && addr == ADDR_MONO_MISC
      |=> rdData == $past(misc_r) ##1 ($past(rdStrobe) || rdData == 16'h0000))
    else $error("read data slot wrong");
  a_res_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (aux3_r & ~MIX_MASK) == 16'h0000 && (misc_r & ~MISC_MASK) == 16'h0000)
    else $error("reserved bits hold ones");
endmodule
`default_nettype wire

// ===== hdl/mixer_ctrl_pkg.sv
// constants shared by the mixer control register bank and its gain deferral unit
// assumes a 125 MHz clock and a 5-bit register address
package mixer_ctrl_pkg;
  localparam int unsigned ADDR_W  = 5;
  localparam int unsigned DATA_W  = 16;

  // register offsets
  localparam logic [4:0]  ADDR_AUX3_MIX  = 5'h06;
  localparam logic [4:0]  ADDR_MIC_MIX   = 5'h07;
  localparam logic [4:0]  ADDR_MONO_MISC = 5'h08;
  localparam logic [4:0]  ADDR_DAC1_GAIN = 5'h09;

  // reset values
  localparam logic [15:0] MIX_RST        = 16'h8888;
  localparam logic [15:0] MISC_RST       = 16'h8868;
  localparam logic [15:0] DAC_GAIN_RST   = 16'h8888;

  // writable bits; reserved positions store and read zero
  localparam logic [15:0] MIX_MASK       = 16'h9F9F;
  localparam logic [15:0] MISC_MASK      = 16'h9FFB;
  localparam logic [15:0] DAC_GAIN_MASK  = 16'hBFBF;

  // field positions
  localparam int unsigned LEFT_MUTE_BIT  = 15;
  localparam int unsigned RIGHT_MUTE_BIT = 7;
  localparam int unsigned LEFT_MIX_LSB   = 8;
  localparam int unsigned RIGHT_MIX_LSB  = 0;
  localparam int unsigned MIX_GAIN_W     = 5;
  localparam int unsigned DAC_GAIN_W     = 6;
  localparam int unsigned ALL_MIX_BIT    = 7;
  localparam int unsigned MONO_OUT_BIT   = 6;
  localparam int unsigned HP_MUTE_BIT    = 5;
  localparam int unsigned HP_SWING_BIT   = 4;
  localparam int unsigned SUM_MUTE_BIT   = 3;
  localparam int unsigned DAC2_TIME_BIT  = 1;
  localparam int unsigned DAC1_TIME_BIT  = 0;

  // deferred gain change timeout, least of the 10 to 12 ms window
  localparam int unsigned DEFER_TIME_MS  = 10;
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned DEFER_CYCLES   = DEFER_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned DEFER_CNT_W    = 21;
endpackage

// ===== hdl/gain_defer_if.sv
// carrier between the register bank and one gain deferral unit
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface gain_defer_if;
  logic [15:0] newWord;    // gain word just written
  logic        load;       // one-cycle write pulse
  logic        immediate;  // change-timing bit
  logic        zeroCross;  // synchronised midscale crossing
  logic        clear;      // force default, drop pending change
  logic [15:0] applied;    // gain word in effect
  logic        pending;    // change waiting
  modport ctl  (output newWord, load, immediate, zeroCross, clear, input applied, pending);
  modport unit (input newWord, load, immediate, zeroCross, clear, output applied, pending);
endinterface
`default_nettype wire

// ===== hdl/gain_defer.sv
// one gain deferral unit: applies a new DAC gain word at once or at the
// next crossing / timeout; assumes zeroCross is already synchronised
`timescale 1ns/1ns
`default_nettype none
module gain_defer #(
  parameter logic [15:0] RST_WORD    = 16'h8888,
  parameter int unsigned DEFER_LIMIT = 1_250_000
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  gain_defer_if.unit       dfr
);
  import mixer_ctrl_pkg::*;

  logic [15:0]            applied_r;
  logic [15:0]            pendWord_r;
  logic                   pending_r;
  logic [DEFER_CNT_W-1:0] count_r;
  wire                    expire = (count_r == DEFER_CNT_W'(DEFER_LIMIT - 1));
  wire                    fire   = pending_r & (dfr.zeroCross | expire | dfr.immediate);

  // apply now, or hold latest word until crossing or timeout
  always_ff @(posedge clk) begin
    if (!reset_n || dfr.clear) begin
      applied_r  <= RST_WORD;
      pendWord_r <= RST_WORD;
      pending_r  <= 1'b0;
      count_r    <= '0;
    end else if (dfr.load && dfr.immediate) begin
      applied_r  <= dfr.newWord;
      pending_r  <= 1'b0;
    end else if (dfr.load) begin
      pendWord_r <= dfr.newWord;   // newest write wins, timer restarts
      pending_r  <= 1'b1;
      count_r    <= '0;
    end else if (fire) begin
      applied_r  <= pendWord_r;
      pending_r  <= 1'b0;
    end else if (pending_r) begin
      count_r    <= count_r + 1'b1;
    end
  end

  assign dfr.applied = applied_r;
  assign dfr.pending = pending_r;

  a_imm_apply: assert property (@(posedge clk) disable iff (!reset_n)
    dfr.load && dfr.immediate && !dfr.clear |=> applied_r == $past(dfr.newWord))
    else $error("immediate gain change not applied");
  a_defer_hold: assert property (@(posedge clk) disable iff (!reset_n)
    dfr.load && !dfr.immediate && !dfr.clear |=> pending_r && applied_r == $past(applied_r))
    else $error("deferred gain applied too early");
  a_cross_apply: assert property (@(posedge clk) disable iff (!reset_n)
    pending_r && dfr.zeroCross && !dfr.load && !dfr.clear
      |=> !pending_r && applied_r == $past(pendWord_r))
    else $error("crossing did not apply pending gain");
  a_timer_bound: assert property (@(posedge clk) disable iff (!reset_n)
    count_r < DEFER_CNT_W'(DEFER_LIMIT))
    else $error("deferral timer ran past its limit");
endmodule
`default_nettype wire

// ===== tb/host_port_model.sv
// host side of the register port: one-cycle write and read strobes
// assumes rdData is registered and stands only in the cycle after rdStrobe
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
  input  wire logic                               clk,
  output logic      [mixer_ctrl_pkg::ADDR_W-1:0]  addr,
  output logic      [mixer_ctrl_pkg::DATA_W-1:0]  wrData,
  output logic                                    wrStrobe,
  output logic                                    rdStrobe,
  input  wire logic [mixer_ctrl_pkg::DATA_W-1:0]  rdData
);
  import mixer_ctrl_pkg::*;
  // idle port at time zero, no strobe before the bench asks
  initial begin
    addr     = '0;
    wrData   = '0;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
  end
  function automatic logic [15:0] keep(input logic [4:0] a);
    case (a)
      ADDR_AUX3_MIX, ADDR_MIC_MIX: keep = MIX_MASK;
      ADDR_MONO_MISC:              keep = MISC_MASK;
      ADDR_DAC1_GAIN:              keep = DAC_GAIN_MASK;
      default:                     keep = 16'hFFFF;
    endcase
  endfunction
  // write: strobe for exactly one sampled edge, fields held with it
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wrStrobe <= 1'b1;
    addr     <= a;
    wrData   <= d & keep(a);
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask
  // read: data taken in the one cycle it stands
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    rdStrobe <= 1'b1;
    addr     <= a;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    d = rdData;
  endtask
endmodule
`default_nettype wire

// ===== tb/codec_mixer_control_registers_tb.sv
// self-checking bench for the mixer control register bank
// assumes a short deferral limit so timeouts fit in a short run
`timescale 1ns/1ns
`default_nettype none
module codec_mixer_control_registers_tb;
  import mixer_ctrl_pkg::*;
  localparam int LIM = 16;
  typedef struct {logic [4:0] a; logic [15:0] w; logic [15:0] r;} row_t;
  logic clk, reset_n, pdn_n, cpd, mixEn, analog_channel_enable, d1En, d2En, zc1, zc2, ld2;
  logic [4:0]  addr;
  logic [15:0] wrData, rdData, w2, ap2, d;
  logic wrStrobe, rdStrobe, pend1, pend2;
  logic lAxM, rAxM, lMcM, rMcM, mnM, allM, mono_out_mute, hpM, hpS, sum_input_mute, lDM, rDM;
  logic [4:0] lAxG, rAxG, lMcG, rMcG, mnG;
  logic [5:0] lDG, rDG;
  int miscompares, comparisons;
  row_t rows [5] = '{'{5'h06, 16'h0A13, 16'h0A13}, '{5'h07, 16'h9F1F, 16'h9F1F},
    '{5'h08, 16'h1F7B, 16'h1F7B}, '{5'h09, 16'h3F25, 16'h3F25}, '{5'h0A, 16'h1234, 16'h0000}};

  host_port_model host (.clk(clk), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData));
  codec_mixer_control_registers #(.DEFER_LIMIT(LIM)) DUT (.clk(clk), .reset_n(reset_n),
    .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .powerDownPin_n(pdn_n), .conversionPowerDown(cpd), .analogInputMixEnable(mixEn),
    .analogChannelEnable(analog_channel_enable), .dac1Enable(d1En), .dac2Enable(d2En), .dac1ZeroCross(zc1),
    .dac2ZeroCross(zc2), .dac2GainWord(w2), .dac2GainLoad(ld2), .leftAux3MixMute(lAxM),
    .leftAux3MixGain(lAxG), .rightAux3MixMute(rAxM), .rightAux3MixGain(rAxG),
    .leftMicMixMute(lMcM), .leftMicMixGain(lMcG), .rightMicMixMute(rMcM),
    .rightMicMixGain(rMcG), .monoInMixMute(mnM), .monoInMixGain(mnG), .allMixMute(allM),
    .monoOutMute(mono_out_mute), .headphoneMute(hpM), .headphoneSwingSel(hpS), .sumInputMute(sum_input_mute),
    .leftDac1AnalogMute(lDM), .leftDac1AnalogGain(lDG), .rightDac1AnalogMute(rDM),
    .rightDac1AnalogGain(rDG), .dac1GainPending(pend1), .dac2AppliedGain(ap2),
    .dac2GainPending(pend2));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic finish_test;
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog, the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  initial begin
    {reset_n, cpd, zc1, zc2, ld2, w2} = '0;
    {pdn_n, mixEn, analog_channel_enable, d1En, d2En} = '1;
    miscompares = 0;
    comparisons = 0;
    cyc(10);
    @(posedge clk) reset_n <= 1'b1;
    cyc(4);
    foreach (rows[i]) rchk(rows[i].a, i < 2 ? MIX_RST : i == 2 ? MISC_RST : i == 3 ? DAC_GAIN_RST : 16'h0);
    chk(16'({lAxM, lAxG, rMcM, rMcG}), 16'h0A28);
    // field layout through write and readback
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].w);
      rchk(rows[i].a, rows[i].r);
    end
    chk(16'({lAxM, lAxG, rAxM, rAxG}), 16'h0293);
    chk(16'({lMcM, lMcG, rMcM, rMcG}), 16'h0FDF);
    chk(16'({mnM, mnG, allM}), 16'h003E);
    chk(16'({mono_out_mute, hpM, hpS, sum_input_mute}), 16'h000F);
    chk(16'({lDM, lDG, rDM, rDG}), 16'h1FA5);
    // all-mix mute overrides enabled paths, output bits clear
    host.wr(5'h08, 16'h0880);
    cyc(2);
    chk(16'({allM, lAxM, rAxM, rMcM, mono_out_mute, hpM, hpS, sum_input_mute}), 16'h00F0);
    host.wr(5'h09, 16'h0A0A);
    cyc(2);
    chk(16'({pend1, lDG}), 16'h007F);
    @(posedge clk) zc1 <= 1'b1;
    cyc(1);
    @(posedge clk) zc1 <= 1'b0;
    cyc(6);
    chk(16'({pend1, lDG, rDG}), 16'h028A);
    // newer write replaces pending value and restarts timeout
    host.wr(5'h09, 16'h0303);
    cyc(8);
    host.wr(5'h09, 16'h0404);
    cyc(10);
    chk(16'({pend1, lDG}), 16'h004A);
    cyc(12);
    chk(16'({pend1, lDG}), 16'h0004);
    // dac2 deferred to timeout, then immediate
    @(posedge clk) {ld2, w2} <= {1'b1, 16'h1111};
    @(posedge clk) ld2 <= 1'b0;
    cyc(2);
    chk(16'(pend2), 16'h0001);
    cyc(22);
    chk(ap2, 16'h1111);
    host.wr(5'h08, 16'h0882);
    @(posedge clk) {ld2, w2} <= {1'b1, 16'h2222};
    @(posedge clk) ld2 <= 1'b0;
    cyc(3);
    chk(16'({pend2, ap2[14:0]}), 16'h2222);
    // mix enable low: mix regs held, misc low byte stays writable
    @(posedge clk) mixEn <= 1'b0;
    cyc(2);
    rchk(5'h06, MIX_RST);
    rchk(5'h08, 16'h8882);
    host.wr(5'h08, 16'h0083);
    host.wr(5'h07, 16'h0101);
    rchk(5'h08, 16'h8883);
    rchk(5'h07, MIX_RST);
    @(posedge clk) mixEn <= 1'b1;
    cyc(2);
    rchk(5'h06, MIX_RST);
    @(posedge clk) cpd <= 1'b1;
    host.wr(5'h08, 16'h0801);
    rchk(5'h08, MISC_RST);
    rchk(5'h09, DAC_GAIN_RST);
    @(posedge clk) cpd <= 1'b0;
    host.wr(5'h07, 16'h0101);
    @(posedge clk) pdn_n <= 1'b0;
    cyc(4);
    host.wr(5'h07, 16'h0202);
    rchk(5'h07, MIX_RST);
    chk(16'(lMcM), 16'h0001);
    @(posedge clk) pdn_n <= 1'b1;
    cyc(4);
    host.wr(5'h06, 16'h0101);
    @(posedge clk) reset_n <= 1'b0;
    cyc(3);
    @(posedge clk) reset_n <= 1'b1;
    cyc(4);
    rchk(5'h06, MIX_RST);
    chk(16'({lAxM, lAxG, pend1, pend2}), 16'h00A0);
    finish_test();
  end
endmodule
`default_nettype wire
